// File: hdl/etc_event_time_comparator.sv
// What this block does
// - Compare running time with preset, emit 10 us pulse
// - Twelve chained 4-bit digit equality stages
// - Rising final equality launches the event pulse
// - Five selectable rates; slower rates use more stages
// - Per-second mode uses first six stages only
// - Day digits never take part in matching
// - Inhibit high blocks pulses, low allows them
// - Outputs A and B each select own rate
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps

module etc_event_time_comparator (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire etc_pkg::etc_digits_type time_digits,
    input wire etc_pkg::etc_digits_type preset_digits,
    input wire etc_pkg::etc_bus_type bus_req,
    output logic [etc_pkg::DATA_W-1:0] bus_rdata,
    output logic event_a,
    output logic event_b
);

    etc_pkg::etc_state_all_type s_reg;
    etc_pkg::etc_state_all_type s_next;

    // Cascade: entry 0 is the always-high head, entry i+1 is the output of stage i
    logic [etc_pkg::NUM_STAGES:0] eq_chain;
    logic [etc_pkg::NUM_CHAN-1:0] match;
    logic [etc_pkg::NUM_CHAN-1:0] start;
    logic [etc_pkg::NUM_CHAN-1:0] eq_prev;
    logic [etc_pkg::NUM_CHAN-1:0][2:0] rate;
    logic [etc_pkg::NUM_STAGES-1:0] cascade;
    logic [etc_pkg::DATA_W-1:0] rd_word;
    logic ctrl_we;
    logic [etc_pkg::NUM_CHAN-1:0] clr_overlap;
    logic [etc_pkg::NUM_CHAN-1:0] clr_count;
    etc_pkg::etc_status_type status;

    assign eq_chain[0] = 1'b1;
    assign cascade = eq_chain[etc_pkg::NUM_STAGES:1];

    genvar gi;
    generate
        for (gi = 0; gi < etc_pkg::NUM_STAGES; gi++) begin : g_stage
            // A stage only reports equality when every stage before it does
            etc_digit_stage stage_inst (
                .eq_in(eq_chain[gi]),
                .time_digit(time_digits[gi]),
                .preset_digit(preset_digits[gi]),
                .eq_out(eq_chain[gi + 1])
            );
        end
    endgenerate

    // The day-of-year digits are not even wired in; the longest rate stops at stage 12
    assign rate[etc_pkg::CHAN_A] = s_reg.ctrl.rate_a;
    assign rate[etc_pkg::CHAN_B] = s_reg.ctrl.rate_b;

    genvar gc;
    generate
        for (gc = 0; gc < etc_pkg::NUM_CHAN; gc++) begin : g_chan
            assign eq_prev[gc] = s_reg.chan[gc].eq_prev;

            etc_rate_match rate_inst (
                .rate(rate[gc]),
                .eq_chain(eq_chain),
                .match(match[gc])
            );

            // Launch on the rising edge only, so a long coincidence gives one pulse
            etc_edge_gate gate_inst (
                .match(match[gc]),
                .eq_prev(eq_prev[gc]),
                .inhibit(s_reg.ctrl.inhibit),
                .start(start[gc])
            );
        end
    endgenerate

    always_comb begin
        status.active[etc_pkg::CHAN_A] = (s_reg.chan[etc_pkg::CHAN_A].state == etc_pkg::ST_FIRE);
        status.active[etc_pkg::CHAN_B] = (s_reg.chan[etc_pkg::CHAN_B].state == etc_pkg::ST_FIRE);
        status.match = match;
        status.overlap[etc_pkg::CHAN_A] = s_reg.chan[etc_pkg::CHAN_A].overlap;
        status.overlap[etc_pkg::CHAN_B] = s_reg.chan[etc_pkg::CHAN_B].overlap;
    end

    etc_write_decode write_inst (
        .bus_req(bus_req),
        .ctrl_we(ctrl_we),
        .clr_overlap(clr_overlap),
        .clr_count(clr_count)
    );

    etc_read_mux read_inst (
        .addr(bus_req.addr),
        .ctrl(s_reg.ctrl),
        .status(status),
        .count_a(s_reg.chan[etc_pkg::CHAN_A].count),
        .count_b(s_reg.chan[etc_pkg::CHAN_B].count),
        .cascade(cascade),
        .rd_word(rd_word)
    );

    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;

        // Software writes come first so that a hardware event in the same cycle wins
        if (ctrl_we) begin
            s_next.ctrl = bus_req.wdata[$bits(etc_pkg::etc_ctrl_type)-1:0];
        end
        for (int ch = 0; ch < etc_pkg::NUM_CHAN; ch++) begin
            if (clr_overlap[ch]) begin
                s_next.chan[ch].overlap = 1'b0;
            end
            if (clr_count[ch]) begin
                s_next.chan[ch].count = etc_pkg::COUNT_ZERO;
            end
        end

        for (int ch = 0; ch < etc_pkg::NUM_CHAN; ch++) begin
            s_next.chan[ch].eq_prev = match[ch];
            case (s_reg.chan[ch].state)
                etc_pkg::ST_IDLE: begin
                    if (start[ch]) begin
                        s_next.chan[ch].state = etc_pkg::ST_FIRE;
                        s_next.chan[ch].cnt = etc_pkg::PULSE_LOAD;
                        s_next.chan[ch].count = s_next.chan[ch].count + etc_pkg::COUNT_ONE;
                    end
                end
                etc_pkg::ST_FIRE: begin
                    // A second edge inside the pulse is only noted, never stretches it
                    if (start[ch]) begin
                        s_next.chan[ch].overlap = 1'b1;
                    end
                    if (s_reg.chan[ch].cnt == etc_pkg::PULSE_DONE) begin
                        s_next.chan[ch].state = etc_pkg::ST_IDLE;
                    end else begin
                        s_next.chan[ch].cnt = s_reg.chan[ch].cnt - 9'h001;
                    end
                end
                default: begin
                    s_next.chan[ch].state = etc_pkg::ST_IDLE;
                end
            endcase
        end

        // Read data is registered so it stands exactly in the cycle after the strobe
        if (bus_req.rd) begin
            s_next.rdata = rd_word;
        end
    end

    // Everything holds while the clock enable is low, including the pulse timer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.ctrl <= etc_pkg::CTRL_RESET;
            s_reg.rdata <= '0;
            for (int ch = 0; ch < etc_pkg::NUM_CHAN; ch++) begin
                s_reg.chan[ch].state <= etc_pkg::ST_IDLE;
                s_reg.chan[ch].cnt <= etc_pkg::PULSE_DONE;
                // Start high so a match standing at reset does not fire
                s_reg.chan[ch].eq_prev <= 1'b1;
                s_reg.chan[ch].overlap <= 1'b0;
                s_reg.chan[ch].count <= etc_pkg::COUNT_ZERO;
            end
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata = s_reg.rdata;
    assign event_a = (s_reg.chan[etc_pkg::CHAN_A].state == etc_pkg::ST_FIRE);
    assign event_b = (s_reg.chan[etc_pkg::CHAN_B].state == etc_pkg::ST_FIRE);

endmodule

module etc_digit_stage (
    input wire logic eq_in,
    input wire logic [etc_pkg::DIGIT_W-1:0] time_digit,
    input wire logic [etc_pkg::DIGIT_W-1:0] preset_digit,
    output logic eq_out
);

    logic [etc_pkg::DIGIT_W-1:0] bit_agree;

    // One agreement bit per weight, so each of the four conditions stays visible
    assign bit_agree = ~(time_digit ^ preset_digit);
    // Equality is qualified by the stage before, so a break anywhere stops the chain
    assign eq_out = eq_in && (&bit_agree);

endmodule

module etc_rate_match (
    input wire logic [2:0] rate,
    input wire logic [etc_pkg::NUM_STAGES:0] eq_chain,
    output logic match
);

    logic [3:0] stages;

    // Codes five to seven select no stages, which silences that output
    always_comb begin
        stages = etc_pkg::etc_rate_stages(rate);
        match = 1'b0;
        if (stages != etc_pkg::STAGES_NONE) begin
            match = eq_chain[stages];
        end
    end

endmodule

module etc_edge_gate (
    input wire logic match,
    input wire logic eq_prev,
    input wire logic inhibit,
    output logic start
);

    logic rise;

    // Inhibit gates new launches and overlap flags alike; a pulse already running completes
    assign rise = match && !eq_prev;
    assign start = rise && !inhibit;

endmodule

module etc_write_decode (
    input wire etc_pkg::etc_bus_type bus_req,
    output logic ctrl_we,
    output logic [etc_pkg::NUM_CHAN-1:0] clr_overlap,
    output logic [etc_pkg::NUM_CHAN-1:0] clr_count
);

    localparam int OVL_LSB = $bits(etc_pkg::etc_status_type) - etc_pkg::NUM_CHAN;

    // Unmapped addresses decode to nothing, so such writes are dropped
    always_comb begin
        ctrl_we = 1'b0;
        clr_overlap = '0;
        clr_count = '0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                etc_pkg::ADDR_CTRL: begin
                    ctrl_we = 1'b1;
                end
                etc_pkg::ADDR_STATUS: begin
                    clr_overlap = bus_req.wdata[OVL_LSB +: etc_pkg::NUM_CHAN];
                end
                etc_pkg::ADDR_COUNT_A: begin
                    clr_count[etc_pkg::CHAN_A] = 1'b1;
                end
                etc_pkg::ADDR_COUNT_B: begin
                    clr_count[etc_pkg::CHAN_B] = 1'b1;
                end
                default: begin
                    ctrl_we = 1'b0;
                end
            endcase
        end
    end

endmodule

module etc_read_mux (
    input wire logic [etc_pkg::ADDR_W-1:0] addr,
    input wire etc_pkg::etc_ctrl_type ctrl,
    input wire etc_pkg::etc_status_type status,
    input wire logic [etc_pkg::COUNT_W-1:0] count_a,
    input wire logic [etc_pkg::COUNT_W-1:0] count_b,
    input wire logic [etc_pkg::NUM_STAGES-1:0] cascade,
    output logic [etc_pkg::DATA_W-1:0] rd_word
);

    // Unused upper bits and unmapped addresses read as zero
    always_comb begin
        rd_word = '0;
        case (addr)
            etc_pkg::ADDR_CTRL: begin
                rd_word = etc_pkg::DATA_W'(ctrl);
            end
            etc_pkg::ADDR_STATUS: begin
                rd_word = etc_pkg::DATA_W'(status);
            end
            etc_pkg::ADDR_COUNT_A: begin
                rd_word = etc_pkg::DATA_W'(count_a);
            end
            etc_pkg::ADDR_COUNT_B: begin
                rd_word = etc_pkg::DATA_W'(count_b);
            end
            etc_pkg::ADDR_CASCADE: begin
                rd_word = etc_pkg::DATA_W'(cascade);
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

endmodule

// File: hdl/etc_pkg.sv
package etc_pkg;

    // Cascade shape: six sub-second digits, then s, 10 s, min, 10 min, h, 10 h
    localparam int NUM_STAGES = 12;
    localparam int DIGIT_W = 4;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int REF_PERIOD_NS = 1000;
    localparam int NS_PER_US = 1000;
    localparam int PULSE_WIDTH_US = 10;
    localparam int PULSE_REF_CYCLES = PULSE_WIDTH_US * NS_PER_US / REF_PERIOD_NS;
    localparam int PULSE_CYCLES = PULSE_REF_CYCLES * REF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 9;
    localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(PULSE_CYCLES - 1);
    localparam logic [PULSE_CNT_W-1:0] PULSE_DONE = 9'h000;

    // Repetition rate codes
    localparam logic [2:0] RATE_SEC = 3'h0;
    localparam logic [2:0] RATE_TEN_SEC = 3'h1;
    localparam logic [2:0] RATE_MIN = 3'h2;
    localparam logic [2:0] RATE_HOUR = 3'h3;
    localparam logic [2:0] RATE_DAY = 3'h4;

    // Cascade stages taking part for each rate
    localparam logic [3:0] STAGES_NONE = 4'h0;
    localparam logic [3:0] STAGES_SEC = 4'h6;
    localparam logic [3:0] STAGES_TEN_SEC = 4'h7;
    localparam logic [3:0] STAGES_MIN = 4'h8;
    localparam logic [3:0] STAGES_HOUR = 4'hA;
    localparam logic [3:0] STAGES_DAY = 4'hC;

    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_A = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_B = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CASCADE = 8'h10;

    localparam int CHAN_A = 0;
    localparam int CHAN_B = 1;
    localparam int NUM_CHAN = 2;
    localparam int COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

    typedef logic [NUM_STAGES-1:0][DIGIT_W-1:0] etc_digits_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } etc_bus_type;

    typedef struct packed {
        logic inhibit;
        logic [2:0] rate_b;
        logic [2:0] rate_a;
    } etc_ctrl_type;

    localparam etc_ctrl_type CTRL_RESET = 7'h40;

    typedef struct packed {
        logic [NUM_CHAN-1:0] overlap;
        logic [NUM_CHAN-1:0] match;
        logic [NUM_CHAN-1:0] active;
    } etc_status_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_FIRE = 1'b1
    } etc_state_type;

    typedef struct packed {
        etc_state_type state;
        logic [PULSE_CNT_W-1:0] cnt;
        logic eq_prev;
        logic overlap;
        logic [COUNT_W-1:0] count;
    } etc_chan_type;

    typedef struct packed {
        etc_ctrl_type ctrl;
        etc_chan_type [NUM_CHAN-1:0] chan;
        logic [DATA_W-1:0] rdata;
    } etc_state_all_type;

    function automatic logic [3:0] etc_rate_stages(input logic [2:0] rate);
        logic [3:0] n;
        case (rate)
            RATE_SEC: n = STAGES_SEC;
            RATE_TEN_SEC: n = STAGES_TEN_SEC;
            RATE_MIN: n = STAGES_MIN;
            RATE_HOUR: n = STAGES_HOUR;
            RATE_DAY: n = STAGES_DAY;
            default: n = STAGES_NONE;
        endcase
        return n;
    endfunction

endpackage

// File: sim/etc_time_source.sv
`timescale 1ns/100ps
module etc_time_source (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic step,
    input wire etc_pkg::etc_digits_type load_val,
    output etc_pkg::etc_digits_type time_digits
);
    function automatic etc_pkg::etc_digits_type bump(input etc_pkg::etc_digits_type d);
        logic c;
        c = 1'b1;
        for (int i = 0; i < 12; i++) begin
            if (c) begin
                // Tens of seconds and minutes stop at 5, hours at 23
                c = d[i] == ((i == 7 || i == 9) ? 4'h5 : (i == 11) ? 4'h2 : 4'h9) ||
                    (i == 10 && d[11] == 4'h2 && d[10] == 4'h3);
                d[i] = c ? 4'h0 : d[i] + 4'h1;
            end
        end
        return d;
    endfunction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            time_digits <= '0;
        end else if (load) begin
            time_digits <= load_val;
        end else if (step) begin
            time_digits <= bump(time_digits);
        end
    end
endmodule

// File: sim/etc_comparator_sva.sv
`timescale 1ns/100ps
module etc_comparator_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire etc_pkg::etc_digits_type time_digits,
    input wire etc_pkg::etc_digits_type preset_digits,
    input wire etc_pkg::etc_bus_type bus_req,
    input wire logic [etc_pkg::DATA_W-1:0] bus_rdata,
    input wire logic event_a,
    input wire logic event_b
);
    localparam logic [9:0] WIDTH = 10'(etc_pkg::PULSE_CYCLES);
    logic [9:0] cnt_a;
    logic [9:0] cnt_b;
    logic inh;
    logic odd;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Mirrors the inhibit bit so a pulse can be tied to it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_a <= '0;
            cnt_b <= '0;
            inh <= 1'b1;
        end else begin
            // Only enabled cycles count, since the pulse timer freezes with the design
            cnt_a <= event_a ? cnt_a + {9'h000, clk_en} : 10'h000;
            cnt_b <= event_b ? cnt_b + {9'h000, clk_en} : 10'h000;
            if (clk_en && bus_req.wr && bus_req.addr == etc_pkg::ADDR_CTRL) begin
                inh <= bus_req.wdata[6];
            end
        end
    end
    assign odd = !(bus_req.addr inside {etc_pkg::ADDR_CTRL, etc_pkg::ADDR_STATUS, etc_pkg::ADDR_COUNT_A,
        etc_pkg::ADDR_COUNT_B, etc_pkg::ADDR_CASCADE});
    a_width_max_a: assert property (cnt_a <= WIDTH) else $error("pulse A too long");
    a_width_max_b: assert property (cnt_b <= WIDTH) else $error("pulse B too long");
    a_width_end_a: assert property ($fell(event_a) |-> cnt_a == WIDTH) else $error("pulse A short");
    a_width_end_b: assert property ($fell(event_b) |-> cnt_b == WIDTH) else $error("pulse B short");
    a_rise_match_a: assert property ($rose(event_a) |-> $past(time_digits[5:0] == preset_digits[5:0]))
        else $error("pulse A without match");
    a_rise_match_b: assert property ($rose(event_b) |-> $past(time_digits[5:0] == preset_digits[5:0]))
        else $error("pulse B without match");
    a_inhibit_blocks: assert property ($rose(event_a) || $rose(event_b) |-> !$past(inh))
        else $error("pulse while inhibited");
    a_rdata_idle: assert property ($past(clk_en && !bus_req.rd) |-> bus_rdata == '0)
        else $error("read data not idle");
    a_unmapped_zero: assert property ($past(clk_en && bus_req.rd && odd) |-> bus_rdata == '0)
        else $error("unmapped read not zero");
    a_freeze_hold: assert property (!$past(clk_en) |-> $stable(event_a) && $stable(event_b))
        else $error("event changed while frozen");
    c_fire_a: cover property ($rose(event_a));
    c_fire_b: cover property ($rose(event_b));
    c_both: cover property ($rose(event_a) && $rose(event_b));
endmodule
bind etc_event_time_comparator etc_comparator_sva etc_comparator_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .time_digits(time_digits), .preset_digits(preset_digits), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .event_a(event_a), .event_b(event_b));

// File: sim/tb_event_time_comparator.sv
`timescale 1ns/100ps
module tb_event_time_comparator;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic load = 1'b0;
    logic step = 1'b0;
    logic clk_en = 1'b1;
    etc_pkg::etc_digits_type ld_val = '0;
    etc_pkg::etc_digits_type preset = '0;
    etc_pkg::etc_digits_type time_digits;
    etc_pkg::etc_bus_type bus_req = '0;
    logic [31:0] bus_rdata;
    logic event_a;
    logic event_b;
    int mismatches = 0;
    int total_checks = 0;
    int st[5] = '{6, 7, 8, 10, 12};
    time t0;
    always #10 ref_clk = ~ref_clk;
    etc_time_source etc_time_source_inst (.ref_clk(ref_clk), .rst_n(rst_n), .load(load), .step(step),
        .load_val(ld_val), .time_digits(time_digits));
    etc_event_time_comparator etc_event_time_comparator_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .time_digits(time_digits), .preset_digits(preset), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .event_a(event_a), .event_b(event_b));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) bus_req.rd <= 1'b0;
        #1 check(bus_rdata, exp);
    endtask
    // Match rises when the 1 us digit steps from 4 to 5
    task automatic arm(input int diff);
        etc_pkg::etc_digits_type v;
        v = {{11{4'h1}}, 4'h4};
        if (diff < 12) v[diff] = 4'h2;
        @(posedge ref_clk) begin
            load <= 1'b1;
            preset <= {{11{4'h1}}, 4'h5};
            ld_val <= v;
        end
        @(posedge ref_clk) load <= 1'b0;
    endtask
    task automatic fire(input logic [1:0] exp);
        @(posedge ref_clk) step <= 1'b1;
        @(posedge ref_clk) step <= 1'b0;
        // The match shows after that edge; the pulse starts at the next one
        @(posedge ref_clk) #1 check(32'({event_b, event_a}), 32'(exp));
        t0 = $time;
    endtask
    task automatic wait_fall(input int ch, input int extra);
        for (int k = 0; k < 600 && (ch ? event_b : event_a) === 1'b1; k++) @(posedge ref_clk) #1;
        check(32'(($time - t0) / etc_pkg::CLK_PERIOD_NS), 32'(etc_pkg::PULSE_CYCLES + extra));
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #600000;
        mismatches++;
        print_verdict;
    end
    initial begin
        int fr;
        int ot;
        time t1;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h00000040);
        arm(12);
        fire(2'h0);
        rd(8'h08, 32'h00000000);
        arm(12);
        wr(8'h00, 32'h00000000);
        fire(2'h3);
        // A second edge inside the pulse must not stretch it
        arm(12);
        t1 = t0;
        fire(2'h3);
        t0 = t1;
        wait_fall(0, 0);
        rd(8'h04, 32'h0000003C);
        rd(8'h08, 32'h00000001);
        rd(8'h0C, 32'h00000001);
        rd(8'h10, 32'h00000FFF);
        wr(8'h04, 32'h00000030);
        rd(8'h04, 32'h0000000C);
        wr(8'h08, 32'h00000000);
        rd(8'h08, 32'h00000000);
        wr(8'h20, 32'h0000003F);
        rd(8'h20, 32'h00000000);
        rd(8'h00, 32'h00000000);
        // A low clock enable freezes the timer, stretching the pulse by as many cycles
        arm(12);
        fire(2'h3);
        @(posedge ref_clk) clk_en <= 1'b0;
        repeat (20) @(posedge ref_clk);
        clk_en <= 1'b1;
        wait_fall(1, 20);
        rd(8'h08, 32'h00000001);
        for (int r = 0; r < 5; r++) begin
            for (int ch = 0; ch < 2; ch++) begin
                fr = r;
                ot = r < 4 ? r + 1 : 5;
                arm(st[r]);
                wr(8'h00, ch ? 32'(ot | (fr << 3)) : 32'(fr | (ot << 3)));
                fire(ch ? 2'h2 : 2'h1);
                wait_fall(ch, 0);
            end
        end
        print_verdict;
    end
endmodule
